// file: hdl/fts_fan_tach_speed_monitor.sv
// Fan tachometer speed monitor with PWM-synchronised measurement and stretching
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps

// Operation
// - Mode bit: 0 standard, 1 enhanced default
// - Reset defaults per channel as documented
// - Glitch filter ahead of edge detection
// - Standard mode counts ticks between edges
// - Counter runs first to last edge, stores count
// - Saturation without edges gives stall FFFFh
// - Too few edges gives slow value
// - Standard mode refreshes after every measurement
// - Enhanced mode measures only in PWM window
// - Monitoring starts after rise plus guard
// - Stretch PWM until edges or limit
// - Stretch limit bounds total PWM high time
// - Stretch disabled: window is duty high time
// - PWM stretches until all linked channels finish
// - Any channel links to any PWM
// - Enhanced update period from PWM option
// - Both transitions count; 2,3,5,9 edges
// - Sticky status when reading exceeds limit
// - Byte reads, other byte frozen until read
// - Readings are read only
// - Optional skip of first three edges, enhanced mode only
// - Edge count and guard option fields
// - Stretch field, code 000 disables
// - Slow bit selects FFFEh or FFFFh
// - Last edge ends measurement and latches count
module fts_fan_tach_speed_monitor #(
    parameter int TICK_DIV = fts_pkg::TICK_DIV_DEF
) (
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       NRST,
    // Register port
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] WR_DATA,
    input  wire logic       WR_EN,
    input  wire logic       RD_EN,
    output logic      [7:0] RD_DATA,
    // Fan pins
    input  wire logic [3:0] FAN_SPEED_INPUT,
    input  wire logic [2:0] PWM_DUTY_IN,
    output logic      [2:0] PWM_OUT
);

    // ************************************************************
    // Declarations
    // ************************************************************
    localparam int NCH  = fts_pkg::NCH;
    localparam int NPWM = fts_pkg::NPWM;

    fts_pkg::fts_topt_t topt_r    [NCH];
    fts_pkg::fts_tcfg_t tcfg_r    [NCH];
    logic [15:0]        lim_r     [NCH];
    logic [15:0]        rdg_r     [NCH];
    logic [7:0]         lo_hold_r [NCH];
    logic [7:0]         hi_hold_r [NCH];
    logic [NCH-1:0]     lo_frz_r;
    logic [NCH-1:0]     hi_frz_r;
    logic [NCH-1:0]     rd_lo;
    logic [NCH-1:0]     rd_hi;
    logic [NCH-1:0]     str_req;
    logic [NCH-1:0]     sts_set;
    logic [NCH-1:0]     sts_r;
    logic [1:0]         popt_r    [NPWM];
    logic [16:0]        upd_cnt_r [NPWM];
    logic [NPWM-1:0]    upd_req_r;
    logic [NPWM-1:0]    pwm_q_r;
    logic [NPWM-1:0]    pwm_rise;
    logic [NPWM-1:0]    pwm_out_r;
    logic [7:0]         div_r;
    logic               tick_r;
    logic [7:0]         rd_data_r;
    logic [7:0]         rd_nxt;

    assign RD_DATA  = rd_data_r;
    assign PWM_OUT  = pwm_out_r;
    assign pwm_rise = PWM_DUTY_IN & ~pwm_q_r;

    // ************************************************************
    // 90 kHz tick
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            div_r  <= 8'h00;
            tick_r <= 1'b0;
        end else if (div_r == 8'(TICK_DIV - 1)) begin
            div_r  <= 8'h00;
            tick_r <= 1'b1;
        end else begin
            div_r  <= div_r + 8'h01;
            tick_r <= 1'b0;
        end
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            for (int n = 0; n < NCH; n++) begin
                topt_r[n] <= fts_pkg::TOPT_RST;
                tcfg_r[n] <= fts_pkg::TCFG_RST;
                lim_r[n]  <= fts_pkg::LIM_RST;
            end
            for (int p = 0; p < NPWM; p++) begin
                popt_r[p] <= fts_pkg::POPT_RST[1:0];
            end
        end else if (WR_EN) begin
            for (int n = 0; n < NCH; n++) begin
                if (ADDR == 8'(fts_pkg::OFF_TOPT + n)) begin
                    topt_r[n] <= WR_DATA;
                end else if (ADDR == 8'(fts_pkg::OFF_TCFG + n)) begin
                    tcfg_r[n] <= WR_DATA;
                end else if (ADDR == 8'(fts_pkg::OFF_LIM + 2 * n)) begin
                    lim_r[n][7:0] <= WR_DATA;
                end else if (ADDR == 8'(fts_pkg::OFF_LIM + 2 * n + 1)) begin
                    lim_r[n][15:8] <= WR_DATA;
                end
            end
            for (int p = 0; p < NPWM; p++) begin
                if (ADDR == 8'(fts_pkg::OFF_POPT + p)) begin
                    popt_r[p] <= WR_DATA[1:0];
                end
            end
        end
    end

    // ************************************************************
    // Status: set by limit compare, write one to clear
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            sts_r <= '0;
        end else if (WR_EN && ADDR == fts_pkg::OFF_STATUS) begin
            sts_r <= (sts_r & ~WR_DATA[NCH-1:0]) | sts_set;
        end else begin
            sts_r <= sts_r | sts_set;
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    always_comb begin
        rd_nxt = 8'h00;
        rd_lo  = '0;
        rd_hi  = '0;
        for (int n = 0; n < NCH; n++) begin
            if (ADDR == 8'(fts_pkg::OFF_TOPT + n)) begin
                rd_nxt = topt_r[n];
            end else if (ADDR == 8'(fts_pkg::OFF_TCFG + n)) begin
                rd_nxt = tcfg_r[n];
            end else if (ADDR == 8'(fts_pkg::OFF_LIM + 2 * n)) begin
                rd_nxt = lim_r[n][7:0];
            end else if (ADDR == 8'(fts_pkg::OFF_LIM + 2 * n + 1)) begin
                rd_nxt = lim_r[n][15:8];
            end else if (ADDR == 8'(fts_pkg::OFF_READ + 2 * n)) begin
                rd_nxt   = lo_frz_r[n] ? lo_hold_r[n] : rdg_r[n][7:0];
                rd_lo[n] = RD_EN;
            end else if (ADDR == 8'(fts_pkg::OFF_READ + 2 * n + 1)) begin
                rd_nxt   = hi_frz_r[n] ? hi_hold_r[n] : rdg_r[n][15:8];
                rd_hi[n] = RD_EN;
            end
        end
        for (int p = 0; p < NPWM; p++) begin
            if (ADDR == 8'(fts_pkg::OFF_POPT + p)) begin
                rd_nxt = {6'h00, popt_r[p]};
            end
        end
        if (ADDR == fts_pkg::OFF_STATUS) begin
            rd_nxt = {4'h0, sts_r};
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            rd_data_r <= 8'h00;
        end else begin
            rd_data_r <= RD_EN ? rd_nxt : 8'h00;
        end
    end

    // ************************************************************
    // Update timers and PWM outputs
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            pwm_q_r   <= '0;
            pwm_out_r <= '0;
            upd_req_r <= '0;
            for (int p = 0; p < NPWM; p++) begin
                upd_cnt_r[p] <= 17'h00000;
            end
        end else begin
            pwm_q_r <= PWM_DUTY_IN;
            for (int p = 0; p < NPWM; p++) begin
                pwm_out_r[p] <= PWM_DUTY_IN[p];
                for (int n = 0; n < NCH; n++) begin
                    if (str_req[n] && 2'(p) == (&tcfg_r[n].link ? 2'h0 : tcfg_r[n].link)) begin
                        pwm_out_r[p] <= 1'b1;
                    end
                end
                if (pwm_rise[p]) begin
                    upd_req_r[p] <= 1'b0;
                end
                if (tick_r) begin
                    if (upd_cnt_r[p] >= fts_pkg::update_ticks(popt_r[p]) - 17'h1) begin
                        upd_cnt_r[p] <= 17'h00000;
                        upd_req_r[p] <= 1'b1;
                    end else begin
                        upd_cnt_r[p] <= upd_cnt_r[p] + 17'h1;
                    end
                end
            end
        end
    end

    // ************************************************************
    // Measurement channels
    // ************************************************************
    for (genvar n = 0; n < NCH; n++) begin : g_ch
        logic              sync1_r;
        logic              sync2_r;
        logic              flt_r;
        logic              flt_q_r;
        logic [1:0]        run_r;
        fts_pkg::fts_state_t st_r;
        logic [15:0]       cnt_r;
        logic [3:0]        edg_r;
        logic [1:0]        skip_r;
        logic [16:0]       el_r;
        logic [5:0]        gcnt_r;
        logic              m2_r;
        logic [1:0]        lk;
        logic              edge_seen;
        logic              cnt_edge;
        logic              last;
        logic              win_end;
        logic              done;
        logic              str_on;
        logic [16:0]       smax;
        logic [15:0]       res;

        assign lk        = (tcfg_r[n].link > 2'h2) ? 2'h0 : tcfg_r[n].link;
        assign str_on    = topt_r[n].stretch != 3'h0;
        assign smax      = fts_pkg::stretch_ticks(topt_r[n].stretch);
        assign edge_seen = flt_r ^ flt_q_r;
        assign cnt_edge  = edge_seen && st_r == fts_pkg::ST_COUNT &&
                           !(tcfg_r[n].ignore3 && m2_r && skip_r != fts_pkg::SKIP_N);
        assign last      = cnt_edge && (edg_r + 4'h1 >= fts_pkg::need_edges(topt_r[n].edges));
        assign win_end   = m2_r && (str_on ? (el_r >= smax) : !PWM_DUTY_IN[lk]);
        assign done      = st_r != fts_pkg::ST_IDLE &&
                           (last || win_end || (tick_r && cnt_r == fts_pkg::CNT_MAX));
        assign str_req[n] = m2_r && st_r != fts_pkg::ST_IDLE && str_on && el_r < smax;
        assign sts_set[n] = tcfg_r[n].int_en && rdg_r[n] > lim_r[n];

        always_comb begin
            if (last) begin
                res = cnt_r;
            end else if (edg_r == 4'h0) begin
                res = fts_pkg::CNT_MAX;
            end else if (tcfg_r[n].slow) begin
                res = fts_pkg::CNT_MAX;
            end else begin
                res = fts_pkg::SLOW_VAL;
            end
        end

        // Input synchroniser and glitch filter
        always_ff @(posedge CLK) begin
            if (!NRST) begin
                sync1_r <= 1'b1;
                sync2_r <= 1'b1;
                flt_r   <= 1'b1;
                flt_q_r <= 1'b1;
                run_r   <= 2'h0;
            end else begin
                sync1_r <= FAN_SPEED_INPUT[n];
                sync2_r <= sync1_r;
                flt_q_r <= flt_r;
                if (sync2_r == flt_r) begin
                    run_r <= 2'h0;
                end else if (run_r == 2'(fts_pkg::FLT_LEN - 1)) begin
                    flt_r <= sync2_r;
                    run_r <= 2'h0;
                end else begin
                    run_r <= run_r + 2'h1;
                end
            end
        end

        // Measurement state machine
        always_ff @(posedge CLK) begin
            if (!NRST) begin
                st_r     <= fts_pkg::ST_IDLE;
                cnt_r    <= 16'h0000;
                edg_r    <= 4'h0;
                skip_r   <= 2'h0;
                el_r     <= 17'h00000;
                gcnt_r   <= 6'h00;
                m2_r     <= 1'b0;
                rdg_r[n] <= fts_pkg::CNT_MAX;
            end else begin
                if (tick_r && el_r != fts_pkg::EL_MAX) begin
                    el_r <= el_r + 17'h1;
                end
                case (st_r)
                    fts_pkg::ST_IDLE: begin
                        cnt_r  <= 16'h0000;
                        edg_r  <= 4'h0;
                        skip_r <= 2'h0;
                        if (!tcfg_r[n].mode) begin
                            st_r <= fts_pkg::ST_COUNT;
                            m2_r <= 1'b0;
                        end else if (upd_req_r[lk] && pwm_rise[lk]) begin
                            st_r   <= fts_pkg::ST_GUARD;
                            m2_r   <= 1'b1;
                            el_r   <= 17'h00000;
                            gcnt_r <= 6'h00;
                        end
                    end
                    fts_pkg::ST_GUARD: begin
                        if (done) begin
                            st_r     <= fts_pkg::ST_IDLE;
                            rdg_r[n] <= res;
                        end else if (tick_r) begin
                            gcnt_r <= gcnt_r + 6'h01;
                            if (gcnt_r + 6'h01 == fts_pkg::guard_ticks(topt_r[n].guard)) begin
                                st_r <= fts_pkg::ST_COUNT;
                            end
                        end
                    end
                    fts_pkg::ST_COUNT: begin
                        if (done) begin
                            st_r     <= fts_pkg::ST_IDLE;
                            rdg_r[n] <= res;
                        end else begin
                            if (edge_seen && !cnt_edge) begin
                                skip_r <= skip_r + 2'h1;
                            end
                            if (cnt_edge) begin
                                edg_r <= edg_r + 4'h1;
                            end
                            if (cnt_edge && edg_r == 4'h0) begin
                                cnt_r <= 16'h0000;
                            end else if (tick_r && cnt_r != fts_pkg::CNT_MAX) begin
                                cnt_r <= cnt_r + 16'h0001;
                            end
                        end
                    end
                    default: begin
                        st_r <= fts_pkg::ST_IDLE;
                    end
                endcase
            end
        end

        // Byte freeze for coherent 16-bit reads; writes never reach rdg_r
        always_ff @(posedge CLK) begin
            if (!NRST) begin
                lo_frz_r[n]  <= 1'b0;
                hi_frz_r[n]  <= 1'b0;
                lo_hold_r[n] <= 8'h00;
                hi_hold_r[n] <= 8'h00;
            end else if (rd_lo[n]) begin
                if (lo_frz_r[n]) begin
                    lo_frz_r[n] <= 1'b0;
                end else begin
                    hi_frz_r[n]  <= 1'b1;
                    hi_hold_r[n] <= rdg_r[n][15:8];
                end
            end else if (rd_hi[n]) begin
                if (hi_frz_r[n]) begin
                    hi_frz_r[n] <= 1'b0;
                end else begin
                    lo_frz_r[n]  <= 1'b1;
                    lo_hold_r[n] <= rdg_r[n][7:0];
                end
            end
        end
    end

endmodule // fts_fan_tach_speed_monitor

// file: include/fts_pkg.sv
// Constants, register map, types and lookup functions of the fan speed monitor
package fts_pkg;

    // ************************************************************
    // Clocking
    // ************************************************************
    localparam int CLK_HZ       = 10_000_000;
    localparam int TICK_HZ      = 90_000;
    localparam int TICK_DIV_DEF = CLK_HZ / TICK_HZ;
    localparam int NCH          = 4;
    localparam int NPWM         = 3;
    localparam int FLT_LEN      = 4;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] OFF_TOPT   = 8'h90;
    localparam logic [7:0] OFF_POPT   = 8'h94;
    localparam logic [7:0] OFF_TCFG   = 8'hA0;
    localparam logic [7:0] OFF_LIM    = 8'hA8;
    localparam logic [7:0] OFF_READ   = 8'hB0;
    localparam logic [7:0] OFF_STATUS = 8'hB8;

    // ************************************************************
    // Field layouts and reset values
    // ************************************************************
    typedef struct packed {
        logic [2:0] stretch;
        logic [1:0] guard;
        logic [1:0] edges;
        logic       rsv;
    } fts_topt_t;

    typedef struct packed {
        logic [1:0] rsv;
        logic       int_en;
        logic       ignore3;
        logic [1:0] link;
        logic       slow;
        logic       mode;
    } fts_tcfg_t;

    typedef enum logic [1:0] {ST_IDLE, ST_GUARD, ST_COUNT} fts_state_t;

    localparam logic [7:0]  TOPT_RST  = 8'hD4;
    localparam logic [7:0]  TCFG_RST  = 8'h21;
    localparam logic [7:0]  POPT_RST  = 8'h02;
    localparam logic [15:0] LIM_RST   = 16'hFFFF;
    localparam logic [15:0] CNT_MAX   = 16'hFFFF;
    localparam logic [15:0] SLOW_VAL  = 16'hFFFE;
    localparam logic [1:0]  SKIP_N    = 2'h3;
    localparam logic [16:0] EL_MAX    = 17'h1FFFF;

    // ************************************************************
    // Times in ms and derived 90 kHz tick counts
    // ************************************************************
    localparam int UPD_300_MS  = 300;
    localparam int UPD_500_MS  = 500;
    localparam int UPD_1000_MS = 1000;
    localparam int STR_50_MS   = 50;
    localparam int STR_100_MS  = 100;
    localparam int STR_200_MS  = 200;
    localparam int STR_400_MS  = 400;
    localparam int STR_600_MS  = 600;
    localparam int STR_800_MS  = 800;
    localparam int STR_950_MS  = 950;

    function automatic logic [16:0] ms_ticks(input int ms);
        return 17'(ms * (TICK_HZ / 1000));
    endfunction

    function automatic logic [3:0] need_edges(input logic [1:0] code);
        case (code)
            2'h0:    return 4'h2;
            2'h1:    return 4'h3;
            2'h2:    return 4'h5;
            default: return 4'h9;
        endcase
    endfunction

    function automatic logic [5:0] guard_ticks(input logic [1:0] code);
        case (code)
            2'h0:    return 6'h08;
            2'h1:    return 6'h10;
            2'h2:    return 6'h20;
            default: return 6'h3F;
        endcase
    endfunction

    function automatic logic [16:0] stretch_ticks(input logic [2:0] code);
        case (code)
            3'h1:    return ms_ticks(STR_50_MS);
            3'h2:    return ms_ticks(STR_100_MS);
            3'h3:    return ms_ticks(STR_200_MS);
            3'h4:    return ms_ticks(STR_400_MS);
            3'h5:    return ms_ticks(STR_600_MS);
            3'h6:    return ms_ticks(STR_800_MS);
            3'h7:    return ms_ticks(STR_950_MS);
            default: return 17'h00000;
        endcase
    endfunction

    function automatic logic [16:0] update_ticks(input logic [1:0] code);
        case (code)
            2'h0:    return ms_ticks(UPD_300_MS);
            2'h1:    return ms_ticks(UPD_500_MS);
            default: return ms_ticks(UPD_1000_MS);
        endcase
    endfunction

endpackage

// file: bench/fts_monitor_sva.sv
// Port assertions of the fan speed monitor
`timescale 1ns/1ps
module fts_monitor_sva #(
    parameter int TICK_DIV = 2
) (
    // Clock and reset
    input wire logic       CLK,
    input wire logic       NRST,
    // Register port
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WR_DATA,
    input wire logic       WR_EN,
    input wire logic       RD_EN,
    input wire logic [7:0] RD_DATA,
    // Fan pins
    input wire logic [3:0] FAN_SPEED_INPUT,
    input wire logic [2:0] PWM_DUTY_IN,
    input wire logic [2:0] PWM_OUT
);
    localparam int STR_LIM = fts_pkg::STR_950_MS * (fts_pkg::TICK_HZ / 1000) * TICK_DIV + 8;
    logic [31:0] str_cnt_r;

    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);

    // Cycles of stretch beyond the raw duty high time
    always_ff @(posedge CLK) begin
        if (!NRST || !PWM_OUT[0])
            str_cnt_r <= 32'h0;
        else if (!PWM_DUTY_IN[0])
            str_cnt_r <= str_cnt_r + 32'h1;
    end

    sequence s_rd_same;
        RD_EN && ADDR == $past(ADDR);
    endsequence

    property p_readback(logic sel);
        (sel && WR_EN) ##1 s_rd_same |=> RD_DATA == $past(WR_DATA, 2);
    endproperty

    a_rd_idle_zero: assert property (!$past(RD_EN) |-> RD_DATA == 8'h00)
        else $error("read data not zero outside read answer");
    a_unmapped_zero: assert property (RD_EN && ADDR == 8'h00 |=> RD_DATA == 8'h00)
        else $error("unmapped read not zero");
    a_pwm_follow: assert property (PWM_DUTY_IN != 3'h0
        |=> (PWM_OUT & $past(PWM_DUTY_IN)) == $past(PWM_DUTY_IN))
        else $error("pwm output lost duty high");
    a_pwm_rise_cause: assert property ((PWM_OUT & ~$past(PWM_OUT) & ~$past(PWM_DUTY_IN)) == 3'h0)
        else $error("pwm output rose without duty");
    a_stretch_bound: assert property (str_cnt_r <= STR_LIM)
        else $error("pwm stretch beyond longest limit");
    a_topt_readback: assert property (p_readback(ADDR[7:2] == 6'h24))
        else $error("option register readback wrong");
    a_limit_readback: assert property (p_readback(ADDR[7:3] == 5'h15))
        else $error("limit register readback wrong");
    a_status_rsv: assert property (RD_EN && ADDR == 8'hB8 |=> RD_DATA[7:4] == 4'h0)
        else $error("reserved status bits set");
endmodule // fts_monitor_sva

bind fts_fan_tach_speed_monitor fts_monitor_sva #(.TICK_DIV(TICK_DIV)) sva_u (
    .CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_EN(WR_EN),
    .RD_EN(RD_EN), .RD_DATA(RD_DATA), .FAN_SPEED_INPUT(FAN_SPEED_INPUT),
    .PWM_DUTY_IN(PWM_DUTY_IN), .PWM_OUT(PWM_OUT));

// file: bench/fts_fan_model.sv
// Three-wire fans driving tachometer pulses
`timescale 1ns/1ps
module fts_fan_model #(
    parameter int HALF = 40
) (
    // Clock
    input  wire logic       clk,
    // Fan control and tach pins
    input  wire logic [3:0] run,
    output logic      [3:0] tach
);
    int cnt_r = 0;
    initial tach = 4'hF;

    // Spinning fans toggle, stopped ones rest at the pull-up level
    always @(posedge clk) begin
        cnt_r <= (cnt_r >= HALF - 1) ? 0 : cnt_r + 1;
        for (int i = 0; i < 4; i++) begin
            if (!run[i])
                tach[i] <= 1'b1;
            else if (cnt_r == HALF - 1)
                tach[i] <= ~tach[i];
        end
    end
endmodule // fts_fan_model

// file: bench/fts_fan_tach_speed_monitor_test.sv
// Self-checking bench of the fan speed monitor
`timescale 1ns/1ps
module fts_fan_tach_speed_monitor_test;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wr_data = 8'h00;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic [7:0]  rd_data;
    logic [3:0]  tach;
    logic [2:0]  duty = 3'h0;
    logic [2:0]  pwm;
    logic [3:0]  run = 4'h3;
    int          errors = 0;
    int          compares = 0;
    int          pc = 0;
    int          n;
    logic [7:0]  b;
    logic [15:0] v;
    logic [15:0] v2;
    logic [15:0] exp_t [4] = '{16'd20, 16'd40, 16'd80, 16'd160};
    logic [7:0]  rst_a [7] = '{8'h90, 8'h94, 8'hA0, 8'hA8, 8'hA9, 8'hB0, 8'hB1};
    logic [7:0]  rst_v [7] = '{8'hD4, 8'h02, 8'h21, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

    fts_fan_tach_speed_monitor #(.TICK_DIV(2)) dut_u (.CLK(clk), .NRST(nrst), .ADDR(addr),
        .WR_DATA(wr_data), .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data),
        .FAN_SPEED_INPUT(tach), .PWM_DUTY_IN(duty), .PWM_OUT(pwm));
    fts_fan_model #(.HALF(40)) fan_u (.clk(clk), .run(run), .tach(tach));

    always #50 clk = ~clk;
    // Duty high 20 of 200 clocks
    always @(posedge clk) begin
        pc <= (pc == 199) ? 0 : pc + 1;
        duty <= {3{pc < 20}};
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic check_in(input logic [15:0] s, input logic [15:0] lo, input logic [15:0] hi);
        check({15'h0, s >= lo && s <= hi}, 16'h0001);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        rd_en <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        addr <= a;
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
        @(posedge clk);
    endtask
    task automatic rd16(input logic [7:0] a, output logic [15:0] d);
        rd(a, d[7:0]);
        rd(a + 8'h01, d[15:8]);
    endtask
    task automatic idle(input int k);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        repeat (k) @(posedge clk);
    endtask
    task automatic end_of_test;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 7; i++) begin
            rd(rst_a[i], b);
            check({8'h00, b}, {8'h00, rst_v[i]});
        end
        rd(8'h00, b);
        check({8'h00, b}, 16'h0000);
        $display("test reset_values done");
        wr(8'hA1, 8'h20);
        wr(8'hA2, 8'h00);
        wr(8'hA3, 8'h00);
        wr(8'hAB, 8'h00);
        wr(8'hAA, 8'h10);
        rd(8'hAA, b);
        check({8'h00, b}, 16'h0010);
        // Every edge count on a standard channel
        for (int c = 0; c < 4; c++) begin
            wr(8'h91, 8'(c * 2));
            rd(8'h91, b);
            check({8'h00, b}, 16'(c * 2));
            idle(900);
            rd16(8'hB2, v);
            check_in(v, exp_t[c] - 16'd2, exp_t[c] + 16'd2);
        end
        rd(8'hB8, b);
        check({8'h00, b}, 16'h0002);
        wr(8'hAA, 8'hFF);
        wr(8'hAB, 8'hFF);
        wr(8'hB8, 8'h0F);
        rd(8'hB8, b);
        check({8'h00, b}, 16'h0000);
        $display("test standard_mode done");
        wr(8'h90, 8'h20);
        wr(8'h94, 8'h00);
        idle(1);
        n = 0;
        for (int t = 0; t < 70000 && n < 10; t++) begin
            @(posedge clk);
            #1 n = (pwm[0] && !duty[0]) ? n + 1 : 0;
        end
        if (n < 10) begin
            $display("unexpected at %0t: no stretched pulse", $time);
            errors++;
        end
        for (int t = 0; t < 500 && pwm[0]; t++) begin
            @(posedge clk);
            #1 n++;
        end
        check_in(16'(n), 16'd10, 16'd150);
        idle(10);
        rd16(8'hB0, v);
        check_in(v, 16'd18, 16'd22);
        wr(8'hB0, 8'h00);
        rd16(8'hB0, v2);
        check(v2, v);
        $display("test enhanced_mode done");
        end_of_test();
    end
endmodule // fts_fan_tach_speed_monitor_test
